//--- ntw_pkg.sv
// Constants, types and register map of the two-level translation block
// ----------------------------------------------------------------------
// Summary of operation
// - Guest tables then nested tables give system address
// - TLB keeps recent complete translations for reuse
// - Nested-translate every guest table address before fetch
// - TLB entries tagged by space tag
// - Entry with space tag zero is invalid
// - Register access in two-level mode touches guest copies only
// - Entry enables two-level mode from control block
// - Every guest exit turns two-level mode off
// - Two-level entry with host paging off is invalid
// - Feature flag reads one
// - Two-level entry saves host base; every entry loads guest paging state
// - Two-level entry loads nested base, other host bits kept
// - Two-level entry with nested base must-be-zero bits set is invalid
// - Two-level entry with bad attribute table encodings is invalid
// - Exit from two-level mode writes guest state back, not nested base
// - Exit from two-level mode restores host base from save area
// - Miss walks guest references through nested tables
// - Guest permissions checked before final nested walk
// - Table lookups are user writes, else nested fault
// - Table walks set accessed and dirty bits
// - Final lookup is user access of guest type
// - Guest paging off: guest physical equals linear
// - Fault info bit 32 final, bit 33 tables
// ----------------------------------------------------------------------
package ntw_pkg;
  localparam int AW = 32;
  localparam int TAGW = 8;
  // Register offsets
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_FEAT = 8'h04;
  localparam logic [7:0] A_TBR = 8'h08;
  localparam logic [7:0] A_PGC = 8'h0c;
  localparam logic [7:0] A_CB_GBASE = 8'h10;
  localparam logic [7:0] A_CB_GCTL = 8'h14;
  localparam logic [7:0] A_CB_NBASE = 8'h18;
  localparam logic [7:0] A_CB_ATLO = 8'h1c;
  localparam logic [7:0] A_CB_ATHI = 8'h20;
  localparam logic [7:0] A_HSAVE = 8'h24;
  localparam logic [7:0] A_EXCODE = 8'h28;
  localparam logic [7:0] A_EXI_LO = 8'h2c;
  localparam logic [7:0] A_EXI_HI = 8'h30;
  localparam logic [7:0] A_EXI_TWO = 8'h34;
  localparam logic [7:0] A_GATLO = 8'h38;
  localparam logic [7:0] A_GATHI = 8'h3c;
  // Command bits and control block field positions
  localparam int CMD_ENTRY = 0;
  localparam int CMD_EXIT = 1;
  localparam int CMD_FLUSH = 2;
  localparam int GCTL_PG = 0;
  localparam int GCTL_TWO = 1;
  localparam int GCTL_TAG = 8;
  // Exit codes
  localparam logic [1:0] EX_NONE = 2'h0;
  localparam logic [1:0] EX_INVALID = 2'h1;
  localparam logic [1:0] EX_NFAULT = 2'h2;
  localparam logic [1:0] EX_SOFT = 2'h3;
  // Table entry bit positions
  localparam int PE_P = 0;
  localparam int PE_RW = 1;
  localparam int PE_US = 2;
  localparam int PE_A = 5;
  localparam int PE_D = 6;
  // Fault info bit positions
  localparam int FI_P = 0;
  localparam int FI_RW = 1;
  localparam int FI_US = 2;
  localparam int FI_ID = 4;
  localparam int FI_FINAL = 32;
  localparam int FI_TABLE = 33;
  // Must-be-zero bits of the nested base
  localparam logic [31:0] NBASE_ZERO_BITS = 32'h0000_0fe7;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Guest access types
  typedef enum logic [1:0] {
    ACC_RD = 2'h0,
    ACC_WR = 2'h1,
    ACC_FETCH = 2'h2
  } ntw_acc_t;
  // Memory request toward table storage
  typedef struct packed {
    logic rd;
    logic wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } ntw_mem_t;
  // Translation answer
  typedef struct packed {
    logic [31:0] spa;
    logic gfault;
    logic nfault;
  } ntw_rsp_t;
endpackage

//--- ntw_tlb.sv
// Space-tagged translation cache with round-robin replacement
`timescale 1ns/1ps
module ntw_tlb import ntw_pkg::*; #(
  parameter int ENTRIES = 8
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_flush,
  input wire logic [TAGW-1:0] i_tag,
  input wire logic [19:0] i_vpn,
  output logic o_hit,
  output logic o_wr_ok,
  output logic [19:0] o_ppn,
  input wire logic i_fill,
  input wire logic [19:0] i_fill_vpn,
  input wire logic [19:0] i_fill_ppn,
  input wire logic i_fill_wr
);
  localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  initial begin
    if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0) $error("ENTRIES must be power of two");
  end
  logic [ENTRIES-1:0] valid;
  logic [TAGW-1:0] tag [ENTRIES];
  logic [19:0] vpn [ENTRIES];
  logic [19:0] ppn [ENTRIES];
  logic [ENTRIES-1:0] wok;
  logic [PW-1:0] victim;
  // ----------------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------------
  always_comb begin
    o_hit = 1'b0;
    o_wr_ok = 1'b0;
    o_ppn = 20'h0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (valid[i] && tag[i] == i_tag && vpn[i] == i_vpn) begin
        o_hit = 1'b1;
        o_wr_ok = wok[i];
        o_ppn = ppn[i];
      end
    end
  end
  // ----------------------------------------------------------------------
  // Fill and flush
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      valid <= '0;
      victim <= '0;
    end else if (i_flush) begin
      valid <= '0;
    end else if (i_fill) begin
      valid[victim] <= 1'b1;
      victim <= victim + 1'b1;
    end
  end
  // Entry contents, no reset needed behind valid
  always_ff @(posedge i_clk) begin
    if (i_fill) begin
      tag[victim] <= i_tag;
      vpn[victim] <= i_fill_vpn;
      ppn[victim] <= i_fill_ppn;
      wok[victim] <= i_fill_wr;
    end
  end
endmodule

//--- ntw_entry_chk.sv
// Consistency checks applied when a guest entry is attempted
`timescale 1ns/1ps
module ntw_entry_chk import ntw_pkg::*; (
  input wire logic i_two,
  input wire logic i_host_pg,
  input wire logic [TAGW-1:0] i_tag,
  input wire logic [31:0] i_nbase,
  input wire logic [63:0] i_attr,
  output logic o_invalid
);
  logic [7:0] bad_attr;
  // ----------------------------------------------------------------------
  // Per-field attribute checks
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_attr
    assign bad_attr[g] = (i_attr[g*8+1 +: 2] == 2'h1) || (i_attr[g*8+3 +: 5] != 5'h0);
  end
  // Combined verdict
  assign o_invalid = (i_tag == '0)
    || (i_two && !i_host_pg)
    || (i_two && (i_nbase & NBASE_ZERO_BITS) != 32'h0)
    || (i_two && bad_attr != 8'h0);
endmodule

//--- ntw_top.sv
// Two-level translation walker, world switch and register port
`timescale 1ns/1ps
module ntw_top import ntw_pkg::*; #(
  parameter int TLB_ENTRIES = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RSTN,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_req_valid,
  input wire logic [31:0] i_req_gla,
  input wire ntw_acc_t i_req_acc,
  input wire logic i_req_user,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output ntw_rsp_t o_rsp,
  output ntw_mem_t o_mem,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  output logic o_two_level_on
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOOK = 3'b001,
    ST_NRD = 3'b011,
    ST_NWB = 3'b010,
    ST_GRD = 3'b110,
    ST_GWB = 3'b111,
    ST_DONE = 3'b101
  } ntw_st_t;
  initial begin
    if (AW != 32) $error("walker serves 32-bit addresses only");
  end

  ntw_st_t state;
  logic on, guest;
  logic host_pg, guest_pg;
  logic [31:0] host_tbr, guest_tbr, host_save, ntb;
  logic [63:0] gattr;
  logic [TAGW-1:0] tag;
  logic [31:0] cb_gbase, cb_nbase;
  logic cb_gpg, cb_two;
  logic [TAGW-1:0] cb_tag;
  logic [63:0] cb_attr;
  logic [1:0] exit_code;
  logic [63:0] exit_info;
  logic [31:0] exit_two;
  logic [31:0] gla, gpa, nent, gent;
  ntw_acc_t acc;
  logic user, glv, nlv, final_ph, g_rw, g_us;
  logic nf, entry_bad, tlb_hit, tlb_wok;
  logic [19:0] tlb_ppn;
  logic need_w;

  wire wr_cmd = i_wr && i_addr == A_CMD;
  wire entry_cmd = wr_cmd && i_wdata[CMD_ENTRY];
  wire exit_evt = (wr_cmd && i_wdata[CMD_EXIT]) || nf;
  wire fill = state == ST_NWB && i_mem_ack && nlv && final_ph;

  // Nested entry address for the current level
  function automatic logic [31:0] n_addr(input logic lv, input logic [31:0] base,
                                         input logic [31:0] ga);
    n_addr = lv ? {base[31:12], ga[21:12], 2'b00} : {base[31:12], ga[31:22], 2'b00};
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  ntw_entry_chk u_chk (
    .i_two(cb_two),
    .i_host_pg(host_pg),
    .i_tag(cb_tag),
    .i_nbase(cb_nbase),
    .i_attr(cb_attr),
    .o_invalid(entry_bad)
  );

  ntw_tlb #(.ENTRIES(TLB_ENTRIES)) u_tlb (
    .i_clk(I_CLK_SYS),
    .i_rstn(I_RSTN),
    .i_flush(wr_cmd && i_wdata[CMD_FLUSH]),
    .i_tag(tag),
    .i_vpn(gla[31:12]),
    .o_hit(tlb_hit),
    .o_wr_ok(tlb_wok),
    .o_ppn(tlb_ppn),
    .i_fill(fill),
    .i_fill_vpn(gla[31:12]),
    .i_fill_ppn(nent[31:12]),
    .i_fill_wr(nent[PE_RW] && g_rw)
  );

  // ----------------------------------------------------------------------
  // Paging state and world switch
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      on <= 1'b0;
      guest <= 1'b0;
      host_pg <= 1'b0;
      guest_pg <= 1'b0;
      host_tbr <= RST_WORD;
      guest_tbr <= RST_WORD;
      host_save <= RST_WORD;
      ntb <= RST_WORD;
      gattr <= '0;
      tag <= '0;
      cb_gbase <= RST_WORD;
      cb_nbase <= RST_WORD;
      cb_gpg <= 1'b0;
      cb_two <= 1'b0;
      cb_tag <= '0;
      cb_attr <= '0;
      exit_code <= EX_NONE;
    end else if (entry_cmd) begin
      if (entry_bad) begin
        exit_code <= EX_INVALID;
      end else begin
        exit_code <= EX_NONE;
        guest <= 1'b1;
        tag <= cb_tag;
        guest_tbr <= cb_gbase;
        guest_pg <= cb_gpg;
        on <= cb_two;
        if (cb_two) begin
          host_save <= host_tbr;
          gattr <= cb_attr;
          ntb <= cb_nbase;
        end
      end
    end else if (exit_evt) begin
      on <= 1'b0;
      guest <= 1'b0;
      exit_code <= nf ? EX_NFAULT : EX_SOFT;
      if (on) begin
        cb_gbase <= guest_tbr;
        cb_gpg <= guest_pg;
        host_tbr <= host_save;
      end
    end else if (i_wr) begin
      unique case (i_addr)
        A_TBR:
          if (on) guest_tbr <= i_wdata;
          else host_tbr <= i_wdata;
        A_PGC:
          if (on) guest_pg <= i_wdata[0];
          else host_pg <= i_wdata[0];
        A_CB_GBASE: cb_gbase <= i_wdata;
        A_CB_GCTL: begin
          cb_gpg <= i_wdata[GCTL_PG];
          cb_two <= i_wdata[GCTL_TWO];
          cb_tag <= i_wdata[GCTL_TAG +: TAGW];
        end
        A_CB_NBASE: cb_nbase <= i_wdata;
        A_CB_ATLO: cb_attr[31:0] <= i_wdata;
        A_CB_ATHI: cb_attr[63:32] <= i_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Nested fault information
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      exit_info <= '0;
      exit_two <= RST_WORD;
    end else if (nf) begin
      exit_info <= '0;
      exit_info[FI_P] <= i_mem_rdata[PE_P];
      exit_info[FI_RW] <= need_w;
      exit_info[FI_US] <= 1'b1;
      exit_info[FI_ID] <= final_ph && acc == ACC_FETCH;
      exit_info[FI_FINAL] <= final_ph;
      exit_info[FI_TABLE] <= !final_ph;
      exit_two <= gpa;
    end
  end

  // Table lookups always count as writes, final ones by guest type
  assign need_w = !final_ph || acc == ACC_WR;
  // Nested fault: not present, not user, or not writable when needed
  assign nf = state == ST_NRD && i_mem_ack && (!i_mem_rdata[PE_P] || !i_mem_rdata[PE_US]
              || (need_w && !i_mem_rdata[PE_RW]));

  // ----------------------------------------------------------------------
  // Walker
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
      o_mem <= '0;
      o_rsp <= '0;
      gla <= RST_WORD;
      gpa <= RST_WORD;
      nent <= RST_WORD;
      gent <= RST_WORD;
      acc <= ACC_RD;
      user <= 1'b0;
      glv <= 1'b0;
      nlv <= 1'b0;
      final_ph <= 1'b0;
      g_rw <= 1'b0;
      g_us <= 1'b0;
    end else if (exit_evt || entry_cmd) begin
      o_mem <= '0;
      o_rsp <= '{spa: RST_WORD, gfault: 1'b0, nfault: nf};
      state <= nf ? ST_DONE : ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:
          if (i_req_valid && on) begin
            gla <= i_req_gla;
            acc <= i_req_acc;
            user <= i_req_user;
            g_rw <= 1'b1;
            g_us <= 1'b1;
            state <= ST_LOOK;
          end
        ST_LOOK: begin
          nlv <= 1'b0;
          if (tlb_hit && (acc != ACC_WR || tlb_wok)) begin
            o_rsp <= '{spa: {tlb_ppn, gla[11:0]}, gfault: 1'b0, nfault: 1'b0};
            state <= ST_DONE;
          end else if (guest_pg) begin
            glv <= 1'b0;
            final_ph <= 1'b0;
            gpa <= {guest_tbr[31:12], gla[31:22], 2'b00};
            o_mem <= '{rd: 1'b1, wr: 1'b0, addr: n_addr(1'b0, ntb,
                      {guest_tbr[31:12], gla[31:22], 2'b00}), wdata: RST_WORD};
            state <= ST_NRD;
          end else begin
            final_ph <= 1'b1;
            gpa <= gla;
            o_mem <= '{rd: 1'b1, wr: 1'b0, addr: n_addr(1'b0, ntb, gla), wdata: RST_WORD};
            state <= ST_NRD;
          end
        end
        ST_NRD:
          if (i_mem_ack) begin
            nent <= i_mem_rdata;
            o_mem <= '{rd: 1'b0, wr: 1'b1, addr: o_mem.addr,
                      wdata: i_mem_rdata | (32'h1 << PE_A) | ((need_w ? 32'h1 : 32'h0) << PE_D)};
            state <= ST_NWB;
          end
        ST_NWB:
          if (i_mem_ack) begin
            if (!nlv) begin
              nlv <= 1'b1;
              o_mem <= '{rd: 1'b1, wr: 1'b0, addr: n_addr(1'b1, nent, gpa), wdata: RST_WORD};
              state <= ST_NRD;
            end else if (final_ph) begin
              o_rsp <= '{spa: {nent[31:12], gpa[11:0]}, gfault: 1'b0, nfault: 1'b0};
              o_mem <= '0;
              state <= ST_DONE;
            end else begin
              o_mem <= '{rd: 1'b1, wr: 1'b0, addr: {nent[31:12], gpa[11:0]}, wdata: RST_WORD};
              state <= ST_GRD;
            end
          end
        ST_GRD:
          if (i_mem_ack) begin
            if (!i_mem_rdata[PE_P]) begin
              o_rsp <= '{spa: RST_WORD, gfault: 1'b1, nfault: 1'b0};
              o_mem <= '0;
              state <= ST_DONE;
            end else begin
              gent <= i_mem_rdata;
              g_rw <= g_rw && i_mem_rdata[PE_RW];
              g_us <= g_us && i_mem_rdata[PE_US];
              o_mem <= '{rd: 1'b0, wr: 1'b1, addr: o_mem.addr, wdata: i_mem_rdata
                        | (32'h1 << PE_A) | ((glv && acc == ACC_WR ? 32'h1 : 32'h0) << PE_D)};
              state <= ST_GWB;
            end
          end
        ST_GWB:
          if (i_mem_ack) begin
            nlv <= 1'b0;
            if (!glv) begin
              glv <= 1'b1;
              gpa <= {gent[31:12], gla[21:12], 2'b00};
              o_mem <= '{rd: 1'b1, wr: 1'b0, addr: n_addr(1'b0, ntb,
                        {gent[31:12], gla[21:12], 2'b00}), wdata: RST_WORD};
              state <= ST_NRD;
            end else if ((acc == ACC_WR && !g_rw) || (user && !g_us)) begin
              o_rsp <= '{spa: RST_WORD, gfault: 1'b1, nfault: 1'b0};
              o_mem <= '0;
              state <= ST_DONE;
            end else begin
              final_ph <= 1'b1;
              gpa <= {gent[31:12], gla[11:0]};
              o_mem <= '{rd: 1'b1, wr: 1'b0, addr: n_addr(1'b0, ntb,
                        {gent[31:12], gla[11:0]}), wdata: RST_WORD};
              state <= ST_NRD;
            end
          end
        ST_DONE: begin
          o_rsp <= '0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Handshake and status outputs
  assign o_req_ready = state == ST_IDLE && on;
  assign o_rsp_valid = state == ST_DONE;
  assign o_two_level_on = on;

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_rdata <= RST_WORD;
    end else if (i_rd) begin
      unique case (i_addr)
        A_CMD: o_rdata <= {30'h0, guest, on};
        A_FEAT: o_rdata <= 32'h0000_0001;
        A_TBR: o_rdata <= on ? guest_tbr : host_tbr;
        A_PGC: o_rdata <= {31'h0, on ? guest_pg : host_pg};
        A_CB_GBASE: o_rdata <= cb_gbase;
        A_CB_GCTL: o_rdata <= {{(24 - TAGW){1'b0}}, cb_tag, 6'h0, cb_two, cb_gpg};
        A_CB_NBASE: o_rdata <= cb_nbase;
        A_CB_ATLO: o_rdata <= cb_attr[31:0];
        A_CB_ATHI: o_rdata <= cb_attr[63:32];
        A_HSAVE: o_rdata <= host_save;
        A_EXCODE: o_rdata <= {30'h0, exit_code};
        A_EXI_LO: o_rdata <= exit_info[31:0];
        A_EXI_HI: o_rdata <= exit_info[63:32];
        A_EXI_TWO: o_rdata <= exit_two;
        A_GATLO: o_rdata <= gattr[31:0];
        A_GATHI: o_rdata <= gattr[63:32];
        default: o_rdata <= RST_WORD;
      endcase
    end else begin
      o_rdata <= RST_WORD;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb_chk @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);

  tag_zero_a: assert property (entry_cmd && cb_tag == '0
    |=> !on && exit_code == EX_INVALID) else $error("entry with zero tag not refused");
  nohost_pg_a: assert property (entry_cmd && cb_two && !host_pg |=> !on)
    else $error("entry without host paging not refused");
  exit_off_a: assert property (exit_evt && !entry_cmd |=> !on ##1
    (!on || $past(entry_cmd))) else $error("exit left two-level mode on");
  host_kept_a: assert property (on && i_wr && i_addr == A_TBR && !exit_evt
    |=> $stable(host_tbr)) else $error("guest write reached host base");
  feature_a: assert property (i_rd && i_addr == A_FEAT |=> o_rdata[0])
    else $error("feature flag not set");
  entry_save_a: assert property (entry_cmd && cb_two && !entry_bad
    |=> host_save == $past(host_tbr) && ntb == $past(cb_nbase))
    else $error("entry did not save host base");
  exit_restore_a: assert property (exit_evt && on && !entry_cmd
    |=> host_tbr == $past(host_save)) else $error("exit did not restore host base");
  nest_first_a: assert property (state == ST_GRD && $past(state) != ST_GRD
    |-> $past(state) == ST_NWB) else $error("guest entry fetched without nested walk");
  table_ad_a: assert property (state == ST_NWB && !final_ph
    |-> o_mem.wdata[PE_A] && o_mem.wdata[PE_D]) else $error("table walk missed accessed or dirty");
  fault_info_a: assert property (nf && !entry_cmd |=> !on
    && exit_info[FI_TABLE] == !$past(final_ph)) else $error("fault info phase bits wrong");
  flat_guest_a: assert property (state == ST_LOOK && !tlb_hit && !guest_pg
    && !exit_evt && !entry_cmd |=> state == ST_NRD && final_ph && gpa == gla)
    else $error("unpaged guest not sent to final walk");
endmodule

//--- ntw_mem_model.sv
// Table storage model answering the walker's memory requests
`timescale 1ns/1ps
module ntw_mem_model import ntw_pkg::*; (
  input wire logic i_clk,
  input wire logic i_bad,
  input wire ntw_mem_t i_mem,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] store [logic [31:0]];
  logic [31:0] dflt;

  // Unwritten entries map to page 2000, user, writable unless i_bad
  assign dflt = i_bad ? 32'h0000_2005 : 32'h0000_2007;

  // Ack one cycle after issue; released data turns over every cycle
  initial begin
    o_ack = 1'b0;
    o_rdata = 32'h0;
  end
  always @(posedge i_clk) begin
    if ((i_mem.rd || i_mem.wr) && !o_ack) begin
      o_ack <= 1'b1;
      o_rdata <= store.exists(i_mem.addr) ? store[i_mem.addr] : dflt;
      if (i_mem.wr) begin
        store[i_mem.addr] = i_mem.wdata;
      end
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

//--- ntw_top_tb.sv
// Self-checking bench for the two-level translation block
`timescale 1ns/1ps
module ntw_top_tb;
  import ntw_pkg::*;
  logic clk, rstn, wr, rd, req_valid, req_ready, rsp_valid, mem_ack, bad, two_on;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, gla, mem_rdata, val;
  ntw_acc_t acc;
  ntw_rsp_t rsp, got;
  ntw_mem_t mem;
  int bad_count, checks, lat;

  ntw_top dut (.I_CLK_SYS(clk), .I_RSTN(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_req_valid(req_valid), .i_req_gla(gla), .i_req_acc(acc),
    .i_req_user(1'b1), .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp(rsp),
    .o_mem(mem), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_two_level_on(two_on));
  ntw_mem_model tables (.i_clk(clk), .i_bad(bad), .i_mem(mem), .o_ack(mem_ack),
    .o_rdata(mem_rdata));

  // ----------------------------------
  // Bus and compare tasks
  // ----------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(name, exp, rdata);
  endtask
  // Load control block, attempt entry, judge refusal or success
  task automatic entry(input logic [31:0] ctl, nbase, attr, input logic inv);
    wreg(A_CB_GCTL, ctl);
    wreg(A_CB_NBASE, nbase);
    wreg(A_CB_ATLO, attr);
    wreg(A_CB_ATHI, 32'h0606_0606);
    wreg(A_CMD, 32'h1);
    @(negedge clk);
    chk("mode", {31'h0, !inv}, {31'h0, two_on});
    if (inv) rchk("exit code", A_EXCODE, 32'h1);
  endtask
  // Hold a request until taken, then time the answer
  task automatic xlate(input logic [31:0] g, input ntw_acc_t a);
    @(posedge clk);
    gla <= g;
    acc <= a;
    req_valid <= 1'b1;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (req_ready !== 1'b1 && lat < 100);
    if (req_ready !== 1'b1) bad_count++;
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (rsp_valid !== 1'b1 && lat < 2000);
    if (rsp_valid !== 1'b1) bad_count++;
    got = rsp;
  endtask

  // ----------------------------------
  // Scenarios
  // ----------------------------------
  task automatic t_regs;
    rchk("feature", A_FEAT, 32'h1);
    rchk("unmapped", 8'hfc, 32'h0);
    $display("register test done");
  endtask
  task automatic t_refuse;
    wreg(A_TBR, 32'h0000_7000);
    wreg(A_PGC, 32'h0);
    entry(32'h0103, 32'h1000, 32'h0606_0606, 1);
    wreg(A_PGC, 32'h1);
    entry(32'h0003, 32'h1000, 32'h0606_0606, 1);
    entry(32'h0103, 32'h1001, 32'h0606_0606, 1);
    entry(32'h0103, 32'h1000, 32'h0606_0602, 1);
    entry(32'h0103, 32'h1000, 32'h0606_0686, 1);
    $display("refusal test done");
  endtask
  task automatic t_nested_only;
    wreg(A_CB_GBASE, 32'h3000);
    entry(32'h0102, 32'h1000, 32'h0606_0606, 0);
    rchk("host save", A_HSAVE, 32'h7000);
    rchk("guest attr", A_GATLO, 32'h0606_0606);
    rchk("guest base", A_TBR, 32'h3000);
    wreg(A_TBR, 32'h9000);
    rchk("guest copy", A_TBR, 32'h9000);
    xlate(32'h0040_5123, ACC_RD);
    chk("spa", 32'h2123, got.spa);
    xlate(32'h0040_5123, ACC_RD);
    chk("hit latency", 32'd2, lat);
    chk("hit spa", 32'h2123, got.spa);
    wreg(A_CMD, 32'h4);
    xlate(32'h0040_5123, ACC_RD);
    chk("miss latency", 32'd10, lat);
    chk("miss spa", 32'h2123, got.spa);
    wreg(A_CMD, 32'h2);
    @(negedge clk);
    chk("mode off", 32'h0, {31'h0, two_on});
    rchk("host base", A_TBR, 32'h7000);
    rchk("cb base", A_CB_GBASE, 32'h9000);
    rchk("cb nested", A_CB_NBASE, 32'h1000);
    $display("nested-only test done");
  endtask
  task automatic t_two_level;
    entry(32'h0203, 32'h1000, 32'h0606_0606, 0);
    xlate(32'h0080_0abc, ACC_WR);
    chk("spa", 32'h2abc, got.spa);
    chk("faults", 32'h0, {30'h0, got.gfault, got.nfault});
    wreg(A_CMD, 32'h2);
    $display("two-level test done");
  endtask
  task automatic t_fault;
    bad <= 1'b1;
    entry(32'h0303, 32'h5000, 32'h0606_0606, 0);
    xlate(32'h00c0_0000, ACC_RD);
    chk("faults", 32'h1, {30'h0, got.gfault, got.nfault});
    rchk("exit code", A_EXCODE, 32'h2);
    rchk("fault info", A_EXI_HI, 32'h2);
    rchk("fault low", A_EXI_LO, 32'h7);
    rchk("fault gpa", A_EXI_TWO, 32'h900c);
    chk("mode off", 32'h0, {31'h0, two_on});
    $display("fault test done");
  endtask

  // ----------------------------------
  // Clock, sequence, watchdog, verdict
  // ----------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {rstn, wr, rd, req_valid, bad, addr, wdata, gla} = '0;
    acc = ACC_RD;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_refuse();
    t_nested_only();
    t_two_level();
    t_fault();
    results();
  end
  initial begin
    #(5000 * 100);
    bad_count++;
    results();
  end
endmodule
